/* File: hw/bank_out_defs.vh */
// Function
// - after reset every bank reads back array contents
// - FFh picks array, 70h status, 90h or 98h identification or query
// - a bank holds its output mode until FFh, 70h, 90h or 98h reaches that bank
// - decoder next state never looks at any bank output mode
// - only the bank matching the command address changes output mode
// - array read to a busy bank gives undefined data; flagged
// - while controller busy, both cycles of program or erase are ignored
`ifndef BANK_OUT_DEFS_VH
`define BANK_OUT_DEFS_VH
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_STATUS  8'h70
`define CMD_READ_SIG     8'h90
`define CMD_READ_CFI     8'h98
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP  8'h20
`define CMD_PROG_SETUP_A 8'h10
`define CMD_PROG_SETUP_B 8'h40
`define CMD_BUF_PROG     8'hE8
`define CMD_CONFIRM      8'hD0
`define MODE_ARRAY       2'h0
`define MODE_STATUS      2'h1
`define MODE_IDENT       2'h2
`endif

/* File: hw/bank_mode_cell.v */
`timescale 1ns/100ps
`include "bank_out_defs.vh"
module bank_mode_cell
(
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // command
    input  wire       sel_i,
    input  wire       load_i,
    input  wire [1:0] mode_i,
    // state
    output reg  [1:0] mode_o
);
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            mode_o <= `MODE_ARRAY;
        else if (sel_i && load_i)
            mode_o <= mode_i;
    end
endmodule // bank_mode_cell

/* File: hw/flash_bank_output_state_select.v */
`timescale 1ns/100ps
`include "bank_out_defs.vh"
module flash_bank_output_state_select
#(
    parameter BANKS = 16,
    parameter BW    = 4
)
(
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // command write
    input  wire             cmd_we_i,
    input  wire [7:0]       cmd_data_i,
    input  wire [BW-1:0]    cmd_bank_i,
    // controller state
    input  wire             pec_busy_i,
    input  wire [BANKS-1:0] bank_busy_i,
    // read side and start
    input  wire [BW-1:0]    rd_bank_i,
    output reg  [1:0]       rd_mode_o,
    output reg              rd_undef_o,
    output reg              pe_start_o,
    output reg  [BW-1:0]    pe_bank_o
);
    // ----------------------------------------
    // output mode decode
    // ----------------------------------------
    reg       mode_load;
    reg [1:0] mode_new;
    always @*
    begin
        mode_load = 1'b0;
        mode_new  = `MODE_ARRAY;
        case (cmd_data_i)
            `CMD_READ_ARRAY:
            begin
                mode_load = 1'b1;
                mode_new  = `MODE_ARRAY;
            end
            `CMD_READ_STATUS:
            begin
                mode_load = 1'b1;
                mode_new  = `MODE_STATUS;
            end
            `CMD_READ_SIG:
            begin
                mode_load = 1'b1;
                mode_new  = `MODE_IDENT;
            end
            `CMD_READ_CFI:
            begin
                mode_load = 1'b1;
                mode_new  = `MODE_IDENT;
            end
            default:
            begin
                mode_load = 1'b0;
                mode_new  = `MODE_ARRAY;
            end
        endcase
    end

    // ----------------------------------------
    // per-bank mode cells
    // ----------------------------------------
    // one small cell per bank keeps the fan-out of the write strobe local
    wire [2*BANKS-1:0] modes;
    wire [BANKS-1:0]   bank_hit;
    genvar g;
    generate
        for (g = 0; g < BANKS; g = g + 1)
        begin : g_bank
            localparam [31:0] BANK_ID = g;
            assign bank_hit[g] = (cmd_bank_i == BANK_ID[BW-1:0]);
            bank_mode_cell u_cell
            (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .sel_i  (bank_hit[g]),
                .load_i (cmd_we_i & mode_load),
                .mode_i (mode_new),
                .mode_o (modes[2*g+1:2*g])
            );
        end
    endgenerate

    // ----------------------------------------
    // undefined-data flags
    // ----------------------------------------
    // a read-array to a busy bank spoils its output until the bank goes idle;
    // a read-array in the same cycle as the clear sets nothing; the clear wins
    reg  [BANKS-1:0] undef_q;
    reg  [BANKS-1:0] undef_d;
    wire             ra_write = cmd_we_i && (cmd_data_i == `CMD_READ_ARRAY);
    integer          k;
    always @*
    begin
        undef_d = undef_q & bank_busy_i;
        for (k = 0; k < BANKS; k = k + 1)
        begin
            if (ra_write && bank_hit[k] && bank_busy_i[k])
                undef_d[k] = 1'b1;
        end
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            undef_q <= {BANKS{1'b0}};
        else
            undef_q <= undef_d;
    end

    // ----------------------------------------
    // two-cycle sequencer (mode independent)
    // ----------------------------------------
    // the bank output modes are never read here, so a status or ident read
    // in between cannot disturb a pending setup
    localparam S_IDLE  = 1'b0;
    localparam S_SETUP = 1'b1;
    reg          st_q;
    reg          st_d;
    reg [BW-1:0] sbank_q;
    reg [BW-1:0] sbank_d;
    reg          start_d;
    reg [BW-1:0] pbank_d;
    reg          is_setup;

    // first-cycle codes of the two-cycle program and erase commands
    always @*
    begin
        case (cmd_data_i)
            `CMD_ERASE_SETUP:
                is_setup = 1'b1;
            `CMD_PROG_SETUP_A:
                is_setup = 1'b1;
            `CMD_PROG_SETUP_B:
                is_setup = 1'b1;
            `CMD_BUF_PROG:
                is_setup = 1'b1;
            default:
                is_setup = 1'b0;
        endcase
    end

    // a D0h confirm after any of these setup codes starts here; program data handling lives elsewhere
    always @*
    begin
        st_d    = st_q;
        sbank_d = sbank_q;
        start_d = 1'b0;
        pbank_d = pe_bank_o;
        if (cmd_we_i)
        begin
            case (st_q)
                S_IDLE:
                begin
                    if (is_setup && !pec_busy_i)
                    begin
                        st_d    = S_SETUP;
                        sbank_d = cmd_bank_i;
                    end
                end
                S_SETUP:
                begin
                    // any write ends the pair; a busy confirm is dropped with it
                    st_d = S_IDLE;
                    // host keeps both cycles in one bank, so confirm uses the setup bank
                    if (!pec_busy_i && cmd_data_i == `CMD_CONFIRM)
                    begin
                        start_d = 1'b1;
                        pbank_d = sbank_q;
                    end
                end
                default:
                    st_d = S_IDLE;
            endcase
        end
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q       <= S_IDLE;
            sbank_q    <= {BW{1'b0}};
            pe_start_o <= 1'b0;
            pe_bank_o  <= {BW{1'b0}};
        end
        else
        begin
            st_q       <= st_d;
            sbank_q    <= sbank_d;
            pe_start_o <= start_d;
            pe_bank_o  <= pbank_d;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // registered so the output mode settles one edge after the bank select
    reg [1:0] rd_mode_d;
    reg       rd_undef_d;
    always @*
    begin
        rd_mode_d  = modes[2*rd_bank_i +: 2];
        rd_undef_d = undef_q[rd_bank_i];
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_mode_o  <= `MODE_ARRAY;
            rd_undef_o <= 1'b0;
        end
        else
        begin
            rd_mode_o  <= rd_mode_d;
            rd_undef_o <= rd_undef_d;
        end
    end
endmodule // flash_bank_output_state_select

/* File: sim/fbos_sva.sv */
`timescale 1ns/100ps
module fbos_sva
#(
    parameter BANKS = 16,
    parameter BW    = 4
)
(
    // clock and reset
    input wire          clk_i,
    input wire          rst_i,
    // command write and controller busy
    input wire          cmd_we_i,
    input wire [7:0]    cmd_data_i,
    input wire [BW-1:0] cmd_bank_i,
    input wire          pec_busy_i,
    // read side and start
    input wire [BW-1:0] rd_bank_i,
    input wire [1:0]    rd_mode_o,
    input wire          pe_start_o,
    input wire [BW-1:0] pe_bank_o
);
    wire h = cmd_we_i && cmd_bank_i == rd_bank_i;
    wire id = cmd_data_i == 8'h90 || cmd_data_i == 8'h98;
    wire m = id || cmd_data_i == 8'hFF || cmd_data_i == 8'h70;
    wire su = cmd_we_i && cmd_data_i == 8'h20;
    wire setup_any = cmd_data_i == 8'h20 || cmd_data_i == 8'h10 || cmd_data_i == 8'h40 || cmd_data_i == 8'hE8;
    // a write after an accepted setup is its second cycle, whatever its code or spacing
    reg pend_q;
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pend_q <= 1'b0;
        else if (cmd_we_i)
            pend_q <= !pend_q && setup_any && !pec_busy_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_array: assert property
        ($fell(rst_i) |-> rd_mode_o == 2'h0 && !pe_start_o) else $error("reset state");
    a_sel_array: assert property
        (h && cmd_data_i == 8'hFF ##1 $stable(rd_bank_i) |=> rd_mode_o == 2'h0) else $error("array");
    a_sel_status: assert property
        (h && cmd_data_i == 8'h70 ##1 $stable(rd_bank_i) |=> rd_mode_o == 2'h1) else $error("status");
    a_sel_ident: assert property
        (h && id ##1 $stable(rd_bank_i) |=> rd_mode_o == 2'h2) else $error("ident");
    a_keep_mode: assert property
        ((!h || !m) ##1 $stable(rd_bank_i) |=> $stable(rd_mode_o)) else $error("mode moved");
    a_pair_start: assert property
        (su && !pec_busy_i && !pend_q ##1 cmd_we_i && cmd_data_i == 8'hD0 && !pec_busy_i
            |=> pe_start_o && pe_bank_o == $past(cmd_bank_i, 2)) else $error("no start");
    a_start_cause: assert property
        (pe_start_o |-> $past(cmd_we_i && cmd_data_i == 8'hD0 && !pec_busy_i)) else $error("stray");
    a_busy_ignore: assert property
        (su && pec_busy_i |=> ##1 !pe_start_o) else $error("busy start");
endmodule // fbos_sva

/* File: sim/host_model.sv */
`timescale 1ns/100ps
module host_model #(parameter BW = 4)
(
    input  wire          clk_i,
    output reg           we_o = 1'b0,
    output reg  [7:0]    data_o = 8'h00,
    output reg  [BW-1:0] bank_o = {BW{1'b0}}
);
    // callers send both cycles of a pair to one bank
    task wr(input [7:0] d, input [BW-1:0] b);
        begin
            @(negedge clk_i);
            we_o = 1'b1;
            data_o = d;
            bank_o = b;
        end
    endtask
    // idle bus carries inverted junk, not the last command
    task idle;
        begin
            @(negedge clk_i);
            we_o = 1'b0;
            data_o = ~data_o;
            bank_o = ~bank_o;
        end
    endtask
endmodule // host_model

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    reg clk_i = 1'b0, rst_i = 1'b1, pec_busy_i = 1'b0;
    reg [15:0] bank_busy_i = 16'h0000;
    reg [3:0] rd_bank_i = 4'h0;
    wire we, undef, start;
    wire [7:0] dat;
    wire [3:0] bnk, pbank;
    wire [1:0] mode;
    integer miscompares = 0, checked = 0, i;
    always #20 clk_i = ~clk_i;
    host_model host_u (.clk_i(clk_i), .we_o(we), .data_o(dat), .bank_o(bnk));
    flash_bank_output_state_select dut_u (.clk_i(clk_i), .rst_i(rst_i), .cmd_we_i(we), .cmd_data_i(dat),
        .cmd_bank_i(bnk), .pec_busy_i(pec_busy_i), .bank_busy_i(bank_busy_i), .rd_bank_i(rd_bank_i),
        .rd_mode_o(mode), .rd_undef_o(undef), .pe_start_o(start), .pe_bank_o(pbank));
    task chk(input [39:0] n, input [3:0] e, input [3:0] g);
        begin
            checked = checked + 1;
            if (g !== e)
            begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task rd(input [3:0] b, input [1:0] e);
        begin
            @(negedge clk_i) rd_bank_i = b;
            @(negedge clk_i) chk("mode", {2'h0, e}, {2'h0, mode});
        end
    endtask
    task mset(input [7:0] c, input [3:0] b, input [1:0] e);
        begin
            host_u.wr(c, b);
            host_u.idle;
            rd(b, e);
        end
    endtask
    task t_modes;
        begin
            rd(4'h3, 2'h0);
            mset(8'h70, 4'h3, 2'h1);
            mset(8'h98, 4'h3, 2'h2);
            mset(8'h50, 4'h3, 2'h2);
            mset(8'hFF, 4'h3, 2'h0);
            mset(8'h90, 4'h3, 2'h2);
            mset(8'h70, 4'hF, 2'h1);
            rd(4'h3, 2'h2);
            rd(4'h0, 2'h0);
        end
    endtask
    task t_pe;
        begin
            mset(8'h70, 4'h5, 2'h1);
            host_u.wr(8'h20, 4'h5);
            host_u.wr(8'hD0, 4'h5);
            host_u.idle;
            chk("start", 4'h1, {3'h0, start});
            chk("pbank", 4'h5, pbank);
            pec_busy_i = 1'b1;
            host_u.wr(8'h20, 4'h5);
            host_u.wr(8'hD0, 4'h5);
            host_u.idle;
            chk("start", 4'h0, {3'h0, start});
            host_u.wr(8'h20, 4'h5);
            host_u.idle;
            pec_busy_i = 1'b0;
            host_u.wr(8'hD0, 4'h5);
            host_u.idle;
            chk("start", 4'h0, {3'h0, start});
        end
    endtask
    task t_undef;
        begin
            bank_busy_i = 16'h0040;
            host_u.wr(8'hFF, 4'h6);
            host_u.idle;
            rd_bank_i = 4'h6;
            @(negedge clk_i) chk("undef", 4'h1, {3'h0, undef});
            bank_busy_i = 16'h0000;
            repeat (2) @(negedge clk_i);
            chk("undef", 4'h0, {3'h0, undef});
        end
    endtask
    task stop_test;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        for (i = 0; i < 16; i = i + 1)
            rd(i[3:0], 2'h0);
        t_modes;
        t_pe;
        t_undef;
        stop_test;
    end
    // tests need under a hundred cycles; 5000 means a hang
    initial
    begin
        #200000;
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule // tb_top
bind flash_bank_output_state_select fbos_sva #(.BANKS(BANKS), .BW(BW)) sva_u
(
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cmd_we_i   (cmd_we_i),
    .cmd_data_i (cmd_data_i),
    .cmd_bank_i (cmd_bank_i),
    .pec_busy_i (pec_busy_i),
    .rd_bank_i  (rd_bank_i),
    .rd_mode_o  (rd_mode_o),
    .pe_start_o (pe_start_o),
    .pe_bank_o  (pe_bank_o)
);
